//--- common/bfiu_pkg.sv
`default_nettype none
package bfiu_pkg;
  // ==========================================================
  // Status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // ==========================================================
  // Reset values and timing counts
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] GPR_RST    = 8'h00;
  localparam logic [7:0] IO_RST     = 8'h00;
  localparam int         EXEC_CYC   = 1;
  localparam logic [1:0] SRAM_EXTRA = 2'h1;
  // ==========================================================
  // Operation codes
  localparam logic [3:0] OP_NOP  = 4'h0;
  localparam logic [3:0] OP_RLC    = 4'h1;
  localparam logic [3:0] OP_RRC    = 4'h2;
  localparam logic [3:0] OP_SBIT   = 4'h3;
  localparam logic [3:0] OP_CBIT   = 4'h4;
  localparam logic [3:0] OP_TSTORE = 4'h5;
  localparam logic [3:0] OP_TLOAD  = 4'h6;
  localparam logic [3:0] OP_SETV   = 4'h7;
  localparam logic [3:0] OP_CLRV   = 4'h8;
  localparam logic [3:0] OP_SETH   = 4'h9;
  localparam logic [3:0] OP_CLRH   = 4'hA;
  localparam logic [3:0] OP_SETS   = 4'hB;
  localparam logic [3:0] OP_CLRS   = 4'hC;
  localparam logic [3:0] OP_MEM  = 4'hD;
  // ==========================================================
  // Execution states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } bfiu_state_t;
endpackage
`default_nettype wire

//--- common/bfiu_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bfiu_mem_if;
  logic       we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr,
               input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface
`default_nettype wire

//--- design/bfiu_regmem.sv
`timescale 1ns/1ps
`default_nettype none
module bfiu_regmem
  import bfiu_pkg::*;
(
  // Clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RST_N,
  // Port
  bfiu_mem_if.mem   port
);
  logic [7:0] mem_q [32];
  logic [7:0] rdata_q;

  // ==========================================================
  // Storage, registered read
  always_ff @(posedge I_CLK)
  begin
    if (port.we)
    begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      rdata_q <= GPR_RST;
    end
    else
    begin
      rdata_q <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

//--- design/bfiu_top.sv
`timescale 1ns/1ps
`default_nettype none
module bfiu_top
  import bfiu_pkg::*;
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  // Instruction issue
  input  wire logic       I_VALID,
  input  wire logic [3:0] I_OP,
  input  wire logic [4:0] I_REG,
  input  wire logic [2:0] I_BIT,
  input  wire logic [4:0] I_IO_ADDR,
  input  wire logic [1:0] I_MEM_CYC,
  input  wire logic       I_MEM_SRAM,
  input  wire logic [7:0] I_IO_RDATA,
  // Register file read data and write port
  input  wire logic [7:0] I_REG_RDATA,
  output var  logic       O_REG_WE,
  output var  logic [4:0] O_REG_WADDR,
  output var  logic [7:0] O_REG_WDATA,
  // I/O write port
  output var  logic       O_IO_WE,
  output var  logic [4:0] O_IO_ADDR,
  output var  logic [7:0] O_IO_WDATA,
  // Status
  output var  logic [7:0] O_FLAGS,
  output var  logic       O_BUSY,
  output var  logic       O_DONE
);
  bfiu_state_t state_q;
  logic [7:0]  flags_q;
  logic [7:0]  res;
  logic [7:0]  src;
  logic [7:0]  io_src;
  logic [1:0]  wait_q;
  logic        take;
  logic [1:0]  mem_total;

  bfiu_mem_if shadow ();

  bfiu_regmem u_shadow (
    .I_CLK   (I_CLK),
    .I_RST_N (I_RST_N),
    .port    (shadow.mem)
  );

  // ==========================================================
  // Operands come from the core, same clock, no synchroniser
  assign src    = I_REG_RDATA;
  assign io_src = I_IO_RDATA;
  assign take   = I_VALID && (state_q == ST_RUN);
  // Only on-chip timing is modelled; external bus waits are not
  assign mem_total = I_MEM_SRAM ? I_MEM_CYC + SRAM_EXTRA : I_MEM_CYC;

  assign shadow.we    = O_REG_WE;
  assign shadow.waddr = O_REG_WADDR;
  assign shadow.wdata = O_REG_WDATA;
  assign shadow.raddr = I_REG;

  // ==========================================================
  // Result datapath
  always_comb
  begin
    res = src;
    case (I_OP)
      OP_RLC:  res = {src[6:0], flags_q[FLG_C]};
      OP_RRC:  res = {flags_q[FLG_C], src[7:1]};
      OP_SBIT:
      begin
        res = io_src;
        res[I_BIT] = 1'b1;
      end
      OP_CBIT:
      begin
        res = io_src;
        res[I_BIT] = 1'b0;
      end
      OP_TLOAD: res[I_BIT] = flags_q[FLG_T];
      default: res = src;
    endcase
  end

  // ==========================================================
  // Status flags, written at the end of the cycle
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      flags_q <= FLAGS_RST;
    end
    else if (take)
    begin
      case (I_OP)
        OP_RLC:
        begin
          flags_q[FLG_C] <= src[7];
          flags_q[FLG_Z] <= (res == 8'h00);
          flags_q[FLG_N] <= res[7];
          flags_q[FLG_V] <= res[7] ^ src[7];
          flags_q[FLG_S] <= res[7] ^ res[7] ^ src[7];
          flags_q[FLG_H] <= src[3];
        end
        OP_RRC:
        begin
          flags_q[FLG_C] <= src[0];
          flags_q[FLG_Z] <= (res == 8'h00);
          flags_q[FLG_N] <= res[7];
          flags_q[FLG_V] <= res[7] ^ src[0];
          flags_q[FLG_S] <= src[0];
        end
        OP_TSTORE: flags_q[FLG_T] <= src[I_BIT];
        OP_SETV:   flags_q[FLG_V] <= 1'b1;
        OP_CLRV:   flags_q[FLG_V] <= 1'b0;
        OP_SETH:   flags_q[FLG_H] <= 1'b1;
        OP_CLRH:   flags_q[FLG_H] <= 1'b0;
        OP_SETS:   flags_q[FLG_S] <= 1'b1;
        OP_CLRS:   flags_q[FLG_S] <= 1'b0;
        default:   flags_q <= flags_q;
      endcase
    end
  end

  // ==========================================================
  // Write ports, one cycle after issue
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_REG_WE    <= 1'b0;
      O_REG_WADDR <= 5'h00;
      O_REG_WDATA <= GPR_RST;
      O_IO_WE     <= 1'b0;
      O_IO_ADDR   <= 5'h00;
      O_IO_WDATA  <= IO_RST;
    end
    else
    begin
      O_REG_WE    <= take && (I_OP == OP_RLC || I_OP == OP_RRC ||
                              I_OP == OP_TLOAD);
      O_REG_WADDR <= I_REG;
      O_REG_WDATA <= res;
      O_IO_WE     <= take && (I_OP == OP_SBIT || I_OP == OP_CBIT);
      O_IO_ADDR   <= I_IO_ADDR;
      O_IO_WDATA  <= res;
    end
  end

  // ==========================================================
  // Sequencing: single-cycle ops, multi-cycle memory ops
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state_q <= ST_RUN;
      wait_q  <= 2'h0;
      O_DONE  <= 1'b0;
      O_BUSY  <= 1'b0;
    end
    else
    begin
      O_DONE <= 1'b0;
      case (state_q)
        ST_RUN:
        begin
          if (take)
          begin
            if (I_OP == OP_MEM && mem_total > 2'(EXEC_CYC))
            begin
              wait_q  <= mem_total - 2'(EXEC_CYC) - 2'h1;
              state_q <= ST_WAIT;
              O_BUSY  <= 1'b1;
            end
            else
            begin
              O_DONE <= 1'b1;
            end
          end
        end
        ST_WAIT:
        begin
          if (wait_q == 2'h0)
          begin
            state_q <= ST_RUN;
            O_DONE  <= 1'b1;
            O_BUSY  <= 1'b0;
          end
          else
          begin
            wait_q <= wait_q - 2'h1;
          end
        end
        default:
        begin
          state_q <= ST_RUN;
          O_BUSY  <= 1'b0;
        end
      endcase
    end
  end

  // Flags output, registered one cycle behind the status flag register
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_FLAGS <= FLAGS_RST;
    end
    else
    begin
      O_FLAGS <= flags_q;
    end
  end
endmodule
`default_nettype wire

//--- testbench/bfiu_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bfiu_sva
  import bfiu_pkg::*;
(
  // Watched ports
  input wire logic       I_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_VALID,
  input wire logic [3:0] I_OP,
  input wire logic [2:0] I_BIT,
  input wire logic [1:0] I_MEM_CYC,
  input wire logic       I_MEM_SRAM,
  input wire logic [7:0] I_IO_RDATA,
  input wire logic [7:0] I_REG_RDATA,
  input wire logic       O_REG_WE,
  input wire logic [7:0] O_REG_WDATA,
  input wire logic       O_IO_WE,
  input wire logic [7:0] O_IO_WDATA,
  input wire logic [7:0] O_FLAGS,
  input wire logic       O_BUSY,
  input wire logic       O_DONE
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic tk;
  assign tk = I_VALID && !O_BUSY;
  property p_done;
    tk && I_OP >= OP_RLC && I_OP <= OP_CLRS |=> O_DONE;
  endproperty
  a_done: assert property (p_done) else $error("late done");
  property p_rol;
    tk && I_OP == OP_RLC |=> O_REG_WE &&
      O_REG_WDATA[7:1] == $past(I_REG_RDATA[6:0]);
  endproperty
  a_rol: assert property (p_rol) else $error("bad left rotate");
  property p_ror;
    tk && I_OP == OP_RRC |=> O_REG_WE &&
      O_REG_WDATA[6:0] == $past(I_REG_RDATA[7:1]);
  endproperty
  a_ror: assert property (p_ror) else $error("bad right rotate");
  property p_iob;
    tk && (I_OP == OP_SBIT || I_OP == OP_CBIT) |=> O_IO_WE && O_IO_WDATA ==
      ($past(I_OP) == OP_SBIT ? $past(I_IO_RDATA) | (8'h01 << $past(I_BIT))
                              : $past(I_IO_RDATA) & ~(8'h01 << $past(I_BIT)))
      ##1 O_FLAGS == $past(O_FLAGS);
  endproperty
  a_iob: assert property (p_iob) else $error("bad io bit op");
  property p_v;
    tk && (I_OP == OP_SETV || I_OP == OP_CLRV) |=> ##1 O_FLAGS[FLG_V] ==
      ($past(I_OP, 2) == OP_SETV) &&
      (O_FLAGS | 8'h08) == ($past(O_FLAGS) | 8'h08);
  endproperty
  a_v: assert property (p_v) else $error("bad overflow flag");
  property p_h;
    tk && (I_OP == OP_SETH || I_OP == OP_CLRH) |=> ##1 O_FLAGS[FLG_H] ==
      ($past(I_OP, 2) == OP_SETH) &&
      (O_FLAGS | 8'h20) == ($past(O_FLAGS) | 8'h20);
  endproperty
  a_h: assert property (p_h) else $error("bad half flag");
  property p_s;
    tk && (I_OP == OP_SETS || I_OP == OP_CLRS) |=> ##1 O_FLAGS[FLG_S] ==
      ($past(I_OP, 2) == OP_SETS) &&
      (O_FLAGS | 8'h10) == ($past(O_FLAGS) | 8'h10);
  endproperty
  a_s: assert property (p_s) else $error("bad sign flag");
  property p_tst;
    tk && I_OP == OP_TSTORE |=> ##1
      O_FLAGS[FLG_T] == $past(I_REG_RDATA[I_BIT], 2);
  endproperty
  a_tst: assert property (p_tst) else $error("bad bit store");
  property p_mem;
    tk && I_OP == OP_MEM && I_MEM_CYC == 2'h2 && I_MEM_SRAM |=>
      (O_BUSY && !O_DONE) [*2] ##1 (O_DONE && !O_BUSY);
  endproperty
  a_mem: assert property (p_mem) else $error("bad sram wait");
endmodule
bind bfiu_top bfiu_sva u_sva (.*);
`default_nettype wire

//--- testbench/test_bit_flag_instruction_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_bit_flag_instruction_unit
  import bfiu_pkg::*;
;
  typedef struct packed {logic [3:0] op; logic [2:0] b; logic [7:0] d;} bfiu_row_t;
  logic       clk = 0, rst_n = 0, valid = 0, msram = 0, rwe, iwe, busy, done;
  logic [3:0] op = OP_NOP;
  logic [2:0] bsel = 3'h0;
  logic [4:0] rsel = 5'h00, ioa = 5'h00, rwa, iwa;
  logic [1:0] mcyc = 2'h1;
  logic [7:0] rd = 8'h00, iord = 8'h00, rwd, iwd, flags, ms = 8'h00;
  logic [7:0] e_rwd, e_iwd;
  int         num_errors = 0, checked = 0, n;
  bfiu_row_t  rows [14] = '{{OP_SETV,3'h0,8'h00}, {OP_SETH,3'h0,8'h00},
    {OP_SETS,3'h0,8'h00}, {OP_CLRV,3'h0,8'h00}, {OP_CLRH,3'h0,8'h00},
    {OP_CLRS,3'h0,8'h00}, {OP_RLC,3'h0,8'h88}, {OP_RLC,3'h0,8'h00},
    {OP_RRC,3'h0,8'h01}, {OP_RRC,3'h0,8'h00}, {OP_SBIT,3'h7,8'h5A},
    {OP_CBIT,3'h0,8'hFF}, {OP_TSTORE,3'h5,8'h20}, {OP_TLOAD,3'h2,8'h00}};
  always #2.5 clk = ~clk;
  bfiu_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_VALID(valid), .I_OP(op),
    .I_REG(rsel), .I_BIT(bsel), .I_IO_ADDR(ioa), .I_MEM_CYC(mcyc),
    .I_MEM_SRAM(msram), .I_IO_RDATA(iord), .I_REG_RDATA(rd), .O_REG_WE(rwe),
    .O_REG_WADDR(rwa), .O_REG_WDATA(rwd), .O_IO_WE(iwe), .O_IO_ADDR(iwa),
    .O_IO_WDATA(iwd), .O_FLAGS(flags), .O_BUSY(busy), .O_DONE(done));
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Reference model; io and register reads share one data value
  task automatic model(input bfiu_row_t r);
    e_rwd = r.d;
    e_iwd = r.d;
    case (r.op)
      OP_RLC, OP_RRC:
      begin
        e_rwd = r.op == OP_RLC ? {r.d[6:0], ms[FLG_C]} : {ms[FLG_C], r.d[7:1]};
        ms[FLG_C] = r.op == OP_RLC ? r.d[7] : r.d[0];
        if (r.op == OP_RLC) ms[FLG_H] = r.d[3];
        ms[FLG_Z] = e_rwd == 8'h00;
        ms[FLG_N] = e_rwd[7];
        ms[FLG_V] = e_rwd[7] ^ ms[FLG_C];
        ms[FLG_S] = ms[FLG_N] ^ ms[FLG_V];
      end
      OP_SBIT: e_iwd[r.b] = 1'b1;
      OP_CBIT: e_iwd[r.b] = 1'b0;
      OP_TSTORE: ms[FLG_T] = r.d[r.b];
      OP_TLOAD: e_rwd[r.b] = ms[FLG_T];
      OP_SETV, OP_CLRV: ms[FLG_V] = r.op == OP_SETV;
      OP_SETH, OP_CLRH: ms[FLG_H] = r.op == OP_SETH;
      OP_SETS, OP_CLRS: ms[FLG_S] = r.op == OP_SETS;
      default: ;
    endcase
  endtask
  task automatic drive(input bfiu_row_t r);
    valid = 1'b1;
    {op, bsel, rd} = r;
    iord = r.d;
  endtask
  task automatic print_verdict;
    $display("TB: checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #(5 * 400);
    num_errors++;
    print_verdict;
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (20) @(negedge clk);
    chk("reset flags", FLAGS_RST, flags);
    chk("reset strobes", 8'h00, {rwe, iwe, busy, done});
    $display("TB: reset over");
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      @(negedge clk);
      drive(rows[i]);
      rsel = 5'(i);
      ioa = 5'(i);
      model(rows[i]);
      @(negedge clk);
      valid = 1'b0;
      chk("done", 8'h01, 8'(done));
      chk("reg we", 8'(rows[i].op inside {OP_RLC, OP_RRC, OP_TLOAD}),
          8'(rwe));
      chk("io we", 8'(rows[i].op inside {OP_SBIT, OP_CBIT}), 8'(iwe));
      if (rwe === 1'b1) chk("reg data", e_rwd, rwd);
      if (rwe === 1'b1) chk("reg addr", 8'(i), 8'(rwa));
      if (iwe === 1'b1) chk("io data", e_iwd, iwd);
      if (iwe === 1'b1) chk("io addr", 8'(i), 8'(iwa));
      @(negedge clk);
      chk("flags", ms, flags);
    end
    $display("TB: table over");
    drive('{OP_RLC, 3'h0, 8'h80});
    model('{OP_RLC, 3'h0, 8'h80});
    @(negedge clk);
    chk("first rotate", e_rwd, rwd);
    drive('{OP_RLC, 3'h0, 8'h00});
    model('{OP_RLC, 3'h0, 8'h00});
    @(negedge clk);
    valid = 1'b0;
    chk("chained carry", e_rwd, rwd);
    @(negedge clk);
    chk("chained flags", ms, flags);
    $display("TB: back to back over");
    {valid, op, mcyc, msram} = {1'b1, OP_MEM, 2'h2, 1'b1};
    @(negedge clk);
    op = OP_SETV;
    chk("busy", 8'h01, 8'(busy));
    @(negedge clk);
    valid = 1'b0;
    for (n = 2; n < 8 && done !== 1'b1; n++) @(negedge clk);
    chk("sram cycles", 8'h03, 8'(n));
    repeat (2) @(negedge clk);
    chk("refused issue", ms, flags);
    chk("busy over", 8'h00, 8'(busy));
    $display("TB: memory wait over");
    print_verdict;
  end
endmodule
`default_nettype wire
